/* rtl/power_adv_pkg.sv */
// Package: property identifiers, message codes, defaults and timing for the property store
package power_adv_pkg;

  // ==========================================================
  // Message format
  localparam logic [7:0] TYPE_REQ = 8'h00;
  localparam logic [7:0] TYPE_RSP = 8'h01;
  localparam logic [7:0] CMD_GET = 8'h00;
  localparam logic [7:0] CMD_SET = 8'h01;
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [7:0] RSP_FAIL = 8'h01;
  localparam logic [7:0] RSP_BAD = 8'h02;
  localparam logic [3:0] HDR_BYTES = 4'h3;
  localparam logic [3:0] RX_BUF_BYTES = 4'h7;
  localparam logic [3:0] RX_OVERRUN = 4'h8;
  localparam logic [2:0] RSP_HDR_BYTES = 3'h2;

  // ==========================================================
  // Property identifiers (the register offsets)
  localparam logic [7:0] ID_BOARD_POWER_OFF_DELAY = 8'h04;
  localparam logic [7:0] ID_POWER_SOURCE_SELECT = 8'h05;
  localparam logic [7:0] ID_ADVERTISING_POLICY = 8'h06;
  localparam logic [7:0] ID_PAIRING_CODE = 8'h07;
  localparam logic [7:0] ID_LINK_INTERVAL_LOW = 8'h08;
  localparam logic [7:0] ID_LINK_INTERVAL_HIGH = 8'h09;

  // ==========================================================
  // Field positions, masks and legal ranges
  localparam int BTN_CTL_BIT = 0;
  localparam int CONN_CTL_BIT = 1;
  localparam int ADV_AFTER_RESET_BIT = 0;
  localparam int NEVER_ADV_BIT = 1;
  localparam logic [7:0] CTL_BYTE_MASK = 8'h03;
  localparam logic [31:0] PAIRING_CODE_MAX = 32'h000F_423F;
  localparam logic [15:0] INTERVAL_LEGAL_MIN = 16'h0006;
  localparam logic [15:0] INTERVAL_LEGAL_MAX = 16'h0C80;

  // ==========================================================
  // Property store layout and factory values
  typedef struct packed {
    logic [15:0] offDelaySec;
    logic [7:0] powerSel;
    logic [7:0] advPolicy;
    logic [31:0] pairCode;
    logic [15:0] intLow;
    logic [15:0] intHigh;
  } props_s;

  localparam props_s PROPS_DEFAULT = '{
    offDelaySec: 16'h003C,
    powerSel: 8'h03,
    advPolicy: 8'h00,
    pairCode: 32'h0000_0000,
    intLow: 16'h000A,
    intHigh: 16'h000A
  };

  // ==========================================================
  // Timing: one second of the off-delay at the 250 MHz clock
  localparam int CLK_MHZ = 32'h0000_00FA;
  localparam int DELAY_UNIT_S = 32'h0000_0001;
  localparam int SEC_CYCLES = DELAY_UNIT_S * CLK_MHZ * 32'h000F_4240;

  // ==========================================================
  // Parser states
  typedef enum logic [1:0] {ST_RECV, ST_EXEC, ST_SEND} parse_state_e;

  // Value length in bytes of a property, zero when unknown
  function automatic logic [2:0] prop_len(input logic [7:0] id);
    case (id)
      ID_BOARD_POWER_OFF_DELAY: prop_len = 3'h2;
      ID_POWER_SOURCE_SELECT: prop_len = 3'h1;
      ID_ADVERTISING_POLICY: prop_len = 3'h1;
      ID_PAIRING_CODE: prop_len = 3'h4;
      ID_LINK_INTERVAL_LOW: prop_len = 3'h2;
      ID_LINK_INTERVAL_HIGH: prop_len = 3'h2;
      default: prop_len = 3'h0;
    endcase
  endfunction

endpackage

/* rtl/board_off_timer.sv */
// Seconds countdown that powers the main board off when no connection follows a button power-up
`timescale 1ns/1ns
`default_nettype none
module board_off_timer #(
  parameter int SEC_CYCLES = power_adv_pkg::SEC_CYCLES
) (
  input wire logic mclk,            // 250 MHz clock
  input wire logic nrst,            // Async reset, active low
  input wire logic arm,             // Start counting, one-cycle pulse
  input wire logic disarm,          // Abandon counting, a level that acts in every cycle it is high
  input wire logic [15:0] delaySec, // Delay in seconds, latched at arm
  output logic expire               // One-cycle pulse when delay elapses
);

  logic armed_r;
  logic [31:0] preCnt_r;
  logic [15:0] secLeft_r;
  logic expire_r;

  // ==========================================================
  // Countdown
  wire logic secTick = armed_r && (preCnt_r == 32'(SEC_CYCLES - 1));
  wire logic lastSec = secTick && (secLeft_r == 16'h0001);

  // Disarm wins over arm so a connection in the same cycle cancels
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      preCnt_r <= 32'h0000_0000;
      secLeft_r <= 16'h0000;
      expire_r <= 1'b0;
    end else begin
      expire_r <= lastSec && !disarm; // [R2]
      if (disarm || lastSec) begin
        armed_r <= 1'b0;
      end else if (arm && delaySec != 16'h0000) begin // [R3]
        armed_r <= 1'b1;
        preCnt_r <= 32'h0000_0000;
        secLeft_r <= delaySec;
      end else if (secTick) begin
        preCnt_r <= 32'h0000_0000;
        secLeft_r <= secLeft_r - 16'h0001;
      end else if (armed_r) begin
        preCnt_r <= preCnt_r + 32'h0000_0001;
      end
    end
  end

  assign expire = expire_r;

  // ==========================================================
  // Checks
  property p_expireFromArmed;
    @(posedge mclk) disable iff (!nrst)
      expire_r |-> $past(armed_r) && !armed_r;
  endproperty
  a_expireFromArmed: assert property (p_expireFromArmed) else $error("expire without armed timer"); // [R2]

  property p_zeroNeverArms;
    @(posedge mclk) disable iff (!nrst)
      (!armed_r && arm && delaySec == 16'h0000 && !disarm) |=> !armed_r;
  endproperty
  a_zeroNeverArms: assert property (p_zeroNeverArms) else $error("zero delay armed timer"); // [R3]

endmodule
`default_nettype wire

/* rtl/power_adv_config.sv */
// Property store, message interpreter and board power / advertising control
// ==========================================================
// Summary of operation
// (R1) Off-delay property 0x04 holds 16-bit seconds, sent high byte first.
// (R2) Board powered by button without a connection turns off after delay; default 60.
// (R3) Off-delay of zero disables the automatic board power-off.
// (R4) Power source byte 0x05: bit0 button, bit1 connection, default 0x03.
// (R5) Button control set: each press-release toggles board power; else no effect.
// (R6) Connection control set: connect powers on, disconnect powers off.
// (R7) Host power command also sets board power.
// (R8) Advertising byte 0x06: bit0 after-reset, bit1 never, default 0x00.
// (R9) After-reset clear: silent until button press-release or USB power.
// (R10) After-reset set: advertise after reset; button cannot stop it.
// (R11) Never bit set suppresses advertising; clear allows it.
// (R12) Pairing code 0x07: four bytes, 0 to 999999, default zero.
// (R13) Pairing code sent low byte first; last byte always zero.
// (R14) Interval low 0x08: 16-bit, low byte first, 1.25 ms units, default 10.
// (R15) Stored low interval feeds the update request minimum field.
// (R16) Interval high 0x09: same format, feeds update request maximum field.
// (R17) Host writes interval values only from 6 through 3200.
// (R18) New interval values apply only after module reset or power cycle.
// (R19) All properties survive module reset and power-off; the store reloads the factory values at power-on reset.
// (R20) Host should write each stored property once, to spare flash.
// (R21) Get: 00 00 id; reply 01 code value.
// (R22) Set: 00 01 id value; reply 01 code.
// (R23) Response code 0 success, 1 failure, 2 bad parameters.
// (R24) Out-of-range or wrong-length set answers bad parameters, store unchanged.
// (R25) Reserved control bits stored as zero and ignored.
`timescale 1ns/1ns
`default_nettype none
module power_adv_config #(
  parameter int SEC_CYCLES = power_adv_pkg::SEC_CYCLES
) (
  input wire logic mclk,                 // 250 MHz clock
  input wire logic nrst,                 // Power-on reset, async, active low
  input wire logic moduleReset,          // Module reset pulse, keeps properties
  input wire logic [7:0] rxByte,         // Request byte
  input wire logic rxValid,              // Request byte strobe
  input wire logic rxLast,               // Last byte of request
  output logic rxBusy,                   // Request bytes now are dropped
  output logic [7:0] txByte,             // Response byte
  output logic txValid,                  // Response byte strobe
  output logic txLast,                   // Last byte of response
  input wire logic buttonRelease,        // Button press-release pulse
  input wire logic connUp,               // Connection established pulse
  input wire logic connDown,             // Connection terminated pulse
  input wire logic usbPowerOn,           // USB power connected pulse
  input wire logic hostPwrValid,         // Host power command pulse
  input wire logic hostPwrOn,            // Power state asked by host
  output logic boardPower,               // Main board power enable
  output logic advertising,              // Advertising enable
  output logic [31:0] pairingCode,       // Stored pairing code
  output logic [15:0] updIntervalMin,    // Update request minimum interval
  output logic [15:0] updIntervalMax     // Update request maximum interval
);

  // ==========================================================
  // State
  power_adv_pkg::parse_state_e state_r;
  power_adv_pkg::props_s props_r;
  power_adv_pkg::props_s propsWr;
  logic [7:0] rxBuf_r [0:6];
  logic [3:0] rxCnt_r;
  logic [3:0] msgLen_r;
  logic [7:0] txBuf_r [0:5];
  logic [2:0] txIdx_r;
  logic [2:0] txLen_r;
  logic [7:0] txByte_r;
  logic txValid_r;
  logic txLast_r;
  logic rxBusy_r;
  logic boardPower_r;
  logic advertising_r;
  logic connected_r;
  logic startup_r;
  logic [15:0] intMin_r;
  logic [15:0] intMax_r;
  logic timerExpire;

  // ==========================================================
  // Request decode
  wire logic [7:0] msgType = rxBuf_r[0];
  wire logic [7:0] cmdId = rxBuf_r[1];
  wire logic [7:0] propId = rxBuf_r[2];
  wire logic [2:0] valBytes = power_adv_pkg::prop_len(propId);
  wire logic isGet = (msgType == power_adv_pkg::TYPE_REQ) && (cmdId == power_adv_pkg::CMD_GET);
  wire logic isSet = (msgType == power_adv_pkg::TYPE_REQ) && (cmdId == power_adv_pkg::CMD_SET);
  wire logic [15:0] valBe16 = {rxBuf_r[3], rxBuf_r[4]}; // [R1]
  wire logic [15:0] valLe16 = {rxBuf_r[4], rxBuf_r[3]}; // [R14] [R16]
  wire logic [31:0] valLe32 = {rxBuf_r[6], rxBuf_r[5], rxBuf_r[4], rxBuf_r[3]}; // [R13]
  wire logic isInterval = (propId == power_adv_pkg::ID_LINK_INTERVAL_LOW) ||
                          (propId == power_adv_pkg::ID_LINK_INTERVAL_HIGH);
  wire logic getLenOk = (msgLen_r == power_adv_pkg::HDR_BYTES);
  wire logic setLenOk = (msgLen_r == ({1'b0, valBytes} + power_adv_pkg::HDR_BYTES));

  // Range checks; a pairing code below the limit also has a zero top byte
  wire logic intervalOk = (valLe16 >= power_adv_pkg::INTERVAL_LEGAL_MIN) &&
                          (valLe16 <= power_adv_pkg::INTERVAL_LEGAL_MAX); // [R17]
  wire logic pairOk = (valLe32 <= power_adv_pkg::PAIRING_CODE_MAX); // [R12] [R13]
  wire logic rangeOk = (propId == power_adv_pkg::ID_PAIRING_CODE) ? pairOk :
                       isInterval ? intervalOk : 1'b1;

  // Response code: unknown command fails, bad id/length/range is bad parameters
  wire logic [7:0] rspCode =
    (!isGet && !isSet) ? power_adv_pkg::RSP_FAIL :
    (valBytes == 3'h0) ? power_adv_pkg::RSP_BAD :
    isGet ? (getLenOk ? power_adv_pkg::RSP_OK : power_adv_pkg::RSP_BAD) :
    (setLenOk && rangeOk) ? power_adv_pkg::RSP_OK : power_adv_pkg::RSP_BAD; // [R23] [R24]
  wire logic rspOk = (rspCode == power_adv_pkg::RSP_OK);
  wire logic doWrite = (state_r == power_adv_pkg::ST_EXEC) && isSet && rspOk; // [R24]

  // Value bytes for a get, first byte sent in the low lane
  wire logic [31:0] getVal =
    (propId == power_adv_pkg::ID_BOARD_POWER_OFF_DELAY) ?
      {16'h0000, props_r.offDelaySec[7:0], props_r.offDelaySec[15:8]} : // [R1]
    (propId == power_adv_pkg::ID_POWER_SOURCE_SELECT) ? {24'h00_0000, props_r.powerSel} :
    (propId == power_adv_pkg::ID_ADVERTISING_POLICY) ? {24'h00_0000, props_r.advPolicy} :
    (propId == power_adv_pkg::ID_PAIRING_CODE) ? props_r.pairCode : // [R13]
    (propId == power_adv_pkg::ID_LINK_INTERVAL_LOW) ? {16'h0000, props_r.intLow} :
    {16'h0000, props_r.intHigh};
  wire logic [2:0] rspLen = (isGet && rspOk) ? (power_adv_pkg::RSP_HDR_BYTES + valBytes) :
                            power_adv_pkg::RSP_HDR_BYTES; // [R21] [R22]

  // ==========================================================
  // Store update; reserved control bits are masked off on the way in
  wire logic hitDelay = (propId == power_adv_pkg::ID_BOARD_POWER_OFF_DELAY);
  wire logic hitSel = (propId == power_adv_pkg::ID_POWER_SOURCE_SELECT);
  wire logic hitAdv = (propId == power_adv_pkg::ID_ADVERTISING_POLICY);
  wire logic hitPair = (propId == power_adv_pkg::ID_PAIRING_CODE);
  wire logic hitLow = (propId == power_adv_pkg::ID_LINK_INTERVAL_LOW);
  wire logic hitHigh = (propId == power_adv_pkg::ID_LINK_INTERVAL_HIGH);
  assign propsWr.offDelaySec = hitDelay ? valBe16 : props_r.offDelaySec; // [R1]
  assign propsWr.powerSel = hitSel ? (rxBuf_r[3] & power_adv_pkg::CTL_BYTE_MASK) :
                            props_r.powerSel; // [R4] [R25]
  assign propsWr.advPolicy = hitAdv ? (rxBuf_r[3] & power_adv_pkg::CTL_BYTE_MASK) :
                             props_r.advPolicy; // [R8] [R25]
  assign propsWr.pairCode = hitPair ? valLe32 : props_r.pairCode; // [R12]
  assign propsWr.intLow = hitLow ? valLe16 : props_r.intLow; // [R14]
  assign propsWr.intHigh = hitHigh ? valLe16 : props_r.intHigh; // [R16]

  // Store keeps its value over module reset; only power-on loads the factory values
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      props_r <= power_adv_pkg::PROPS_DEFAULT; // [R2] [R4] [R8] [R12] [R14]
    end else if (doWrite) begin
      props_r <= propsWr; // [R19]
    end
  end

  // ==========================================================
  // Message parser
  wire logic rxTake = rxValid && (state_r == power_adv_pkg::ST_RECV);
  wire logic [3:0] rxCntInc = (rxCnt_r == power_adv_pkg::RX_OVERRUN) ? rxCnt_r :
                              (rxCnt_r + 4'h1);
  wire logic txDone = (state_r == power_adv_pkg::ST_SEND) && (txIdx_r == (txLen_r - 3'h1));

  // Bytes beyond the buffer are counted so an over-long set is refused
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= power_adv_pkg::ST_RECV;
      rxCnt_r <= 4'h0;
      msgLen_r <= 4'h0;
      txIdx_r <= 3'h0;
      txLen_r <= 3'h0;
    end else begin
      case (state_r)
        power_adv_pkg::ST_RECV: begin
          if (rxTake) begin
            rxCnt_r <= rxLast ? 4'h0 : rxCntInc;
            msgLen_r <= rxCntInc;
            if (rxLast) begin
              state_r <= power_adv_pkg::ST_EXEC;
            end
          end
        end
        power_adv_pkg::ST_EXEC: begin
          txIdx_r <= 3'h0;
          txLen_r <= rspLen;
          state_r <= power_adv_pkg::ST_SEND;
        end
        power_adv_pkg::ST_SEND: begin
          txIdx_r <= txIdx_r + 3'h1;
          if (txDone) begin
            state_r <= power_adv_pkg::ST_RECV;
          end
        end
        default: begin
          state_r <= power_adv_pkg::ST_RECV;
        end
      endcase
    end
  end

  // Request buffer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 7; i++) begin
        rxBuf_r[i] <= 8'h00;
      end
    end else if (rxTake && rxCnt_r < power_adv_pkg::RX_BUF_BYTES) begin
      rxBuf_r[rxCnt_r[2:0]] <= rxByte;
    end
  end

  // Response buffer, filled in the execute cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) begin
        txBuf_r[i] <= 8'h00;
      end
    end else if (state_r == power_adv_pkg::ST_EXEC) begin
      txBuf_r[0] <= power_adv_pkg::TYPE_RSP; // [R21] [R22]
      txBuf_r[1] <= rspCode; // [R23]
      for (int i = 0; i < 4; i++) begin
        txBuf_r[i + 2] <= getVal[8 * i +: 8];
      end
    end
  end

  // Response byte stream, one byte a cycle with no stall
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txByte_r <= 8'h00;
      txValid_r <= 1'b0;
      txLast_r <= 1'b0;
      rxBusy_r <= 1'b0;
    end else begin
      txByte_r <= (state_r == power_adv_pkg::ST_SEND) ? txBuf_r[txIdx_r] : 8'h00;
      txValid_r <= (state_r == power_adv_pkg::ST_SEND);
      txLast_r <= txDone;
      rxBusy_r <= (rxTake && rxLast) || (state_r == power_adv_pkg::ST_EXEC) ||
                  ((state_r == power_adv_pkg::ST_SEND) && !txDone);
    end
  end

  // ==========================================================
  // Board power
  wire logic btnCtl = props_r.powerSel[power_adv_pkg::BTN_CTL_BIT]; // [R25]
  wire logic connCtl = props_r.powerSel[power_adv_pkg::CONN_CTL_BIT]; // [R25]
  wire logic btnPwr = btnCtl && buttonRelease; // [R5]
  wire logic pwrAfterBtn = btnPwr ? !boardPower_r : boardPower_r; // [R5]
  wire logic pwrAfterConn = (connCtl && connDown) ? 1'b0 :
                            (connCtl && connUp) ? 1'b1 : pwrAfterBtn; // [R6]
  wire logic pwrAfterTmo = timerExpire ? 1'b0 : pwrAfterConn; // [R2]
  wire logic pwrNxt = hostPwrValid ? hostPwrOn : pwrAfterTmo; // [R7]
  wire logic connNxt = connUp ? 1'b1 : connDown ? 1'b0 : connected_r;
  // Only a button power-up without a link starts the off-delay
  wire logic timerArm = btnPwr && !boardPower_r && pwrNxt && !connNxt; // [R2]
  wire logic timerDisarm = connUp || !pwrNxt || hostPwrValid;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      boardPower_r <= 1'b0;
      connected_r <= 1'b0;
    end else begin
      boardPower_r <= pwrNxt;
      connected_r <= moduleReset ? 1'b0 : connNxt;
    end
  end

  board_off_timer #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_offTimer (
    .mclk(mclk),
    .nrst(nrst),
    .arm(timerArm),
    .disarm(timerDisarm),
    .delaySec(props_r.offDelaySec), // [R3]
    .expire(timerExpire)
  );

  // ==========================================================
  // Advertising and applied intervals
  // Startup flag replays the reset policy once the power-on reset is released
  wire logic loadNow = moduleReset || startup_r;
  wire logic advAfterReset = props_r.advPolicy[power_adv_pkg::ADV_AFTER_RESET_BIT];
  wire logic neverAdv = props_r.advPolicy[power_adv_pkg::NEVER_ADV_BIT]; // [R11]
  wire logic advBtn = buttonRelease && !advAfterReset; // [R9] [R10]
  wire logic advRaw = loadNow ? advAfterReset : // [R10]
                      usbPowerOn ? 1'b1 :
                      advBtn ? !advertising_r : advertising_r; // [R9]
  wire logic advNxt = advRaw && !neverAdv; // [R11]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      startup_r <= 1'b1;
      advertising_r <= 1'b0;
      intMin_r <= power_adv_pkg::PROPS_DEFAULT.intLow;
      intMax_r <= power_adv_pkg::PROPS_DEFAULT.intHigh;
    end else begin
      startup_r <= 1'b0;
      advertising_r <= advNxt;
      if (loadNow) begin
        intMin_r <= props_r.intLow; // [R15] [R18]
        intMax_r <= props_r.intHigh; // [R16] [R18]
      end
    end
  end

  assign rxBusy = rxBusy_r;
  assign txByte = txByte_r;
  assign txValid = txValid_r;
  assign txLast = txLast_r;
  assign boardPower = boardPower_r;
  assign advertising = advertising_r;
  assign pairingCode = props_r.pairCode;
  assign updIntervalMin = intMin_r;
  assign updIntervalMax = intMax_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_btnToggle;
    (btnPwr && !connUp && !connDown && !timerExpire && !hostPwrValid) |=>
      boardPower_r != $past(boardPower_r);
  endproperty
  a_btnToggle: assert property (p_btnToggle) else $error("button did not toggle power"); // [R5]

  property p_btnIgnored;
    (buttonRelease && !btnCtl && !connUp && !connDown && !timerExpire && !hostPwrValid)
      |=> $stable(boardPower_r);
  endproperty
  a_btnIgnored: assert property (p_btnIgnored) else $error("disabled button changed power"); // [R5]

  property p_connUp;
    (connCtl && connUp && !connDown && !timerExpire && !hostPwrValid) |=> boardPower_r;
  endproperty
  a_connUp: assert property (p_connUp) else $error("connection did not power board"); // [R6]

  property p_hostPwr;
    hostPwrValid |=> boardPower_r == $past(hostPwrOn);
  endproperty
  a_hostPwr: assert property (p_hostPwr) else $error("host power command ignored"); // [R7]

  property p_neverAdv;
    (neverAdv && $past(neverAdv)) |-> !advertising_r;
  endproperty
  a_neverAdv: assert property (p_neverAdv) else $error("advertising while never bit set"); // [R11]

  property p_reservedZero;
    (props_r.powerSel[7:2] == 6'h00) && (props_r.advPolicy[7:2] == 6'h00);
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bits stored"); // [R25]

  property p_pairRange;
    props_r.pairCode <= power_adv_pkg::PAIRING_CODE_MAX;
  endproperty
  a_pairRange: assert property (p_pairRange) else $error("pairing code out of range"); // [R12]

  property p_intervalHold;
    !loadNow |=> $stable(intMin_r) && $stable(intMax_r);
  endproperty
  a_intervalHold: assert property (p_intervalHold) else $error("interval applied early"); // [R18]

  property p_refusedKeeps;
    (state_r == power_adv_pkg::ST_EXEC && !doWrite) |=> $stable(props_r);
  endproperty
  a_refusedKeeps: assert property (p_refusedKeeps) else $error("refused set changed store"); // [R24]

  property p_rspHeader;
    (state_r == power_adv_pkg::ST_EXEC) |-> ##2 txValid_r &&
      (txByte_r == power_adv_pkg::TYPE_RSP) ##1 txValid_r && (txByte_r == $past(rspCode, 2));
  endproperty
  a_rspHeader: assert property (p_rspHeader) else $error("bad response header"); // [R21] [R22]

  c_getOk: cover property (state_r == power_adv_pkg::ST_EXEC && isGet && rspOk);
  c_setOk: cover property (doWrite);
  c_setBad: cover property (state_r == power_adv_pkg::ST_EXEC && isSet && !rspOk);
  c_offExpire: cover property (timerExpire);

endmodule
`default_nettype wire

/* test/host_link.sv */
// Host model sending request bytes to the property store
`timescale 1ns/1ns
`default_nettype none
module host_link (
  input wire logic mclk, // Clock
  output logic [7:0] rxByte, // Request byte
  output logic rxValid, // Byte strobe
  output logic rxLast // Last byte flag
);
  // ==========
  // Sender; first byte in bits 7:0, released data shows inverse
  task automatic send(input logic [55:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      rxByte = m[8*i +: 8];
      rxValid = 1'b1;
      rxLast = (i == n - 1);
    end
    @(negedge mclk);
    rxByte = ~rxByte;
    rxValid = 1'b0;
    rxLast = 1'b0;
  endtask
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxLast = 1'b0;
  end
endmodule
`default_nettype wire

/* test/test_wireless_module_power_adv_config.sv */
// Self-checking bench for the property store and power control
`timescale 1ns/1ns
`default_nettype none
module test_wireless_module_power_adv_config;
  logic mclk, nrst, moduleReset, buttonRelease, connUp, connDown, usbPowerOn;
  logic hostPwrValid, hostPwrOn, rxValid, rxLast, rxBusy, txValid, txLast;
  logic boardPower, advertising;
  logic [7:0] rxByte, txByte;
  logic [7:0] expQ[$];
  logic [15:0] updIntervalMin, updIntervalMax, w;
  logic [31:0] pairingCode, v;
  int fail_count = 0, compares = 0, cyc = 0;
  host_link u_host (.mclk, .rxByte, .rxValid, .rxLast);
  power_adv_config #(.SEC_CYCLES(10)) u_dut (.mclk, .nrst, .moduleReset, .rxByte,
    .rxValid, .rxLast, .rxBusy, .txByte, .txValid, .txLast, .buttonRelease, .connUp,
    .connDown, .usbPowerOn, .hostPwrValid, .hostPwrOn, .boardPower, .advertising,
    .pairingCode, .updIntervalMin, .updIntervalMax);
  // ==========
  // Clock, timeout, checks
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Response watcher takes the oldest note; an empty queue never matches
  // Sampled on the falling edge, where the registered outputs have settled
  always @(negedge mclk) begin
    cyc++;
    if (cyc > 6000) begin
      fail_count++;
      give_verdict();
    end else if (txValid === 1'b1) begin
      chk(txByte, expQ.size() ? expQ.pop_front() : 32'hffff_ffff);
      if (txLast === 1'b1) chk(expQ.size(), 0);
    end
  end
  task automatic req(input logic [55:0] m, input int n, input logic [47:0] e, input int k);
    for (int i = 0; i < k; i++) expQ.push_back(e[8*i +: 8]);
    u_host.send(m, n);
    chk(rxBusy, 1'b1);
    for (int i = 0; i < 40 && txLast !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    chk(expQ.size(), 0);
    chk(rxBusy, 1'b0);
  endtask
  // Two idle cycles after a pulse so its effect has landed
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  initial begin
    {nrst, moduleReset, buttonRelease, connUp, connDown, usbPowerOn} = '0;
    {hostPwrValid, hostPwrOn} = '0;
    v = $urandom(33542);
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    req(56'h04_0000, 3, 48'h3c00_0001, 4);
    req(56'h05_0000, 3, 48'h03_0001, 3);
    req(56'h06_0000, 3, 48'h00_0001, 3);
    req(56'h07_0000, 3, 48'h0001, 6);
    req(56'h08_0000, 3, 48'h000a_0001, 4);
    req(56'h09_0000, 3, 48'h000a_0001, 4);
    req(56'h0200, 2, 48'h0101, 2);
    req(56'h0a_0000, 3, 48'h0201, 2);
    v = $urandom % 1000000;
    req({v, 24'h07_0100}, 7, 48'h0001, 2);
    req({32'h000f_4240, 24'h07_0100}, 7, 48'h0201, 2);
    req(56'h07_0000, 3, {v, 16'h0001}, 6);
    chk(pairingCode, v);
    req(56'hff_050100, 4, 48'h0001, 2);
    req(56'h05_0000, 3, 48'h03_0001, 3);
    req(56'h02_0004_0100, 5, 48'h0001, 2);
    w = 16'h0006 + 16'($urandom % 3195);
    req({w, 24'h08_0100}, 5, 48'h0001, 2);
    req(56'h0c81_090100, 5, 48'h0201, 2);
    chk(updIntervalMin, 16'h000a);
    req(56'h01_0601_00, 4, 48'h0001, 2);
    pulse(moduleReset);
    chk(updIntervalMin, w);
    chk(updIntervalMax, 16'h000a);
    chk(advertising, 1'b1);
    req(56'h07_0000, 3, {v, 16'h0001}, 6);
    pulse(buttonRelease);
    chk({boardPower, advertising}, 2'b11);
    repeat (12) @(negedge mclk);
    chk(boardPower, 1'b1);
    repeat (14) @(negedge mclk);
    chk(boardPower, 1'b0);
    pulse(connUp);
    chk(boardPower, 1'b1);
    pulse(connDown);
    chk(boardPower, 1'b0);
    hostPwrOn = 1'b1;
    pulse(hostPwrValid);
    chk(boardPower, 1'b1);
    hostPwrOn = 1'b0;
    pulse(hostPwrValid);
    chk(boardPower, 1'b0);
    req(56'h00_0004_0100, 5, 48'h0001, 2);
    pulse(buttonRelease);
    repeat (40) @(negedge mclk);
    chk(boardPower, 1'b1);
    // Both power sources off: button and disconnect leave the board alone
    req(56'h00_050100, 4, 48'h0001, 2);
    pulse(buttonRelease);
    pulse(connDown);
    chk(boardPower, 1'b1);
    // Silent after reset until a button press or USB power
    req(56'h00_0601_00, 4, 48'h0001, 2);
    pulse(moduleReset);
    chk(advertising, 1'b0);
    pulse(buttonRelease);
    chk(advertising, 1'b1);
    pulse(moduleReset);
    pulse(usbPowerOn);
    chk(advertising, 1'b1);
    req(56'h02_0601_00, 4, 48'h0001, 2);
    pulse(moduleReset);
    pulse(usbPowerOn);
    chk(advertising, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
